/* rtl/psbm_params.svh */
// constants for the program-space boot map block
`ifndef PSBM_PARAMS_SVH
`define PSBM_PARAMS_SVH
`define PSBM_ADDR_W 21
`define PSBM_RESET_VEC_INT 21'h040000
`define PSBM_WDOG_VEC_INT 21'h040002
`define PSBM_RESET_VEC_EXT16 21'h000000
`define PSBM_WDOG_VEC_EXT16 21'h000002
`define PSBM_RESET_VEC_EXT20 21'h040000
`define PSBM_WDOG_VEC_EXT20 21'h040002
`define PSBM_LOW_FLASH_TOP 21'h00FFFF
`define PSBM_MID_FLASH_TOP 21'h01FFFF
`define PSBM_HI_FLASH_TOP 21'h03FFFF
`define PSBM_BOOT_FLASH_BASE 21'h040000
`define PSBM_BOOT_FLASH_TOP 21'h043FFF
`define PSBM_RSVD_TOP 21'h04F7FF
`define PSBM_PRAM_BASE 21'h04F800
`define PSBM_PRAM_TOP 21'h04FFFF
`define PSBM_EXT16_LIMIT 21'h00FFFF
`define PSBM_EXT20_LIMIT 21'h0FFFFF
`define PSBM_NARROW_LINES 5'h10
`define PSBM_WIDE_LINES 5'h14
`define PSBM_SHADOW_LINES 5'h12
`endif

/* rtl/psbm_pkg.sv */
// types for the program-space boot map block
package psbm_pkg;
  typedef enum logic [2:0] {
    PSBM_TGT_FLASH_A = 3'h0,
    PSBM_TGT_FLASH_B = 3'h1,
    PSBM_TGT_BOOT_FLASH = 3'h2,
    PSBM_TGT_PRAM = 3'h3,
    PSBM_TGT_RESERVED = 3'h4,
    PSBM_TGT_EXTERNAL = 3'h5
  } psbm_target_t;
  typedef enum logic [1:0] {
    PSBM_ST_RESET = 2'h0,
    PSBM_ST_RUN = 2'h1
  } psbm_state_t;
endpackage : psbm_pkg

/* rtl/psbm_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psbm_sync2 (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic stage1;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : psbm_sync2

/* rtl/psbm_boot_map.sv */
// boot-mode latch and program-space address decoder
`timescale 1ns/1ps
`include "psbm_params.svh"
module psbm_boot_map (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic flash_unsecured,
  input wire logic external_boot_strap,
  input wire logic wide_address_strap,
  input wire logic map_select_wr,
  input wire logic map_select_wdata,
  input wire logic security_flag_wr,
  input wire logic security_flag_wdata,
  input wire logic [20:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic flash_a_busy,
  input wire logic flash_b_busy,
  output logic boot_map_select,
  output logic security_mode_flag,
  output logic external_boot,
  output logic wide_address,
  output logic debug_enable,
  output logic ext_pspace_allowed,
  output logic [4:0] ext_addr_lines,
  output logic [3:0] upper_addr_pin_en,
  output logic chip_select_strobe_mode,
  output logic [20:0] reset_vector,
  output logic [20:0] watchdog_reset_vector,
  output logic [2:0] fetch_target,
  output logic fetch_to_external,
  output logic fetch_beyond_pins,
  output logic fetch_stall,
  output logic init_done
);
  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  logic sec_s;
  logic boot_s;
  logic wide_s;
  psbm_sync2 u_sync_sec (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din(flash_unsecured),
    .dout(sec_s)
  );

  psbm_sync2 u_sync_boot (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din(external_boot_strap),
    .dout(boot_s)
  );

  psbm_sync2 u_sync_wide (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din(wide_address_strap),
    .dout(wide_s)
  );

  // ---------------------------------------------------------------
  // capture sequencer
  // ---------------------------------------------------------------
  // straps are caught once the synchronisers have filled after release
  psbm_pkg::psbm_state_t state;
  psbm_pkg::psbm_state_t next_state;
  logic [1:0] fill_cnt;
  wire fill_done = (fill_cnt == 2'h3);
  wire capture = (state == psbm_pkg::PSBM_ST_RESET) && fill_done;

  always_comb begin
    case (state)
      psbm_pkg::PSBM_ST_RESET: next_state = fill_done ? psbm_pkg::PSBM_ST_RUN : psbm_pkg::PSBM_ST_RESET;
      psbm_pkg::PSBM_ST_RUN: next_state = psbm_pkg::PSBM_ST_RUN;
      default: next_state = psbm_pkg::PSBM_ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= psbm_pkg::PSBM_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // counter stops at its top; capture cannot repeat because it also needs the reset state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fill_cnt <= 2'h0;
    end else if (!fill_done) begin
      fill_cnt <= fill_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // captured mode bits
  // ---------------------------------------------------------------
  logic sec_cap;
  logic wide_cap;
  // flag only follows flash state at capture; writes are ignored
  wire next_sec_flag = capture ? sec_s : security_mode_flag;
  // secured flash forces the request low, giving the 00 case
  wire boot_req_ok = boot_s & sec_s;
  wire run_ok = (state == psbm_pkg::PSBM_ST_RUN);
  // a 1 write is dropped unless unsecured at reset
  wire sel_wr_val = map_select_wdata & sec_cap;
  wire next_map_sel = capture ? boot_req_ok :
                      (run_ok && map_select_wr) ? sel_wr_val : boot_map_select;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      security_mode_flag <= 1'b0;
      boot_map_select <= 1'b0;
    end else begin
      security_mode_flag <= next_sec_flag;
      boot_map_select <= next_map_sel;
    end
  end

  // private copies keep the decode free of the software-visible bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sec_cap <= 1'b0;
      wide_cap <= 1'b0;
      init_done <= 1'b0;
    end else if (capture) begin
      sec_cap <= sec_s;
      wide_cap <= wide_s;
      init_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  logic boot_ext_cap;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boot_ext_cap <= 1'b0;
    end else if (capture) begin
      boot_ext_cap <= boot_req_ok;
    end
  end

  // wide strap only counts for external boot; otherwise 16 lines
  wire cfg_wide = boot_ext_cap & wide_cap;
  wire [4:0] cfg_lines = cfg_wide ? `PSBM_WIDE_LINES : `PSBM_NARROW_LINES;
  // ext20 keeps the internal vector words, only the memory behind them moves
  wire [20:0] ext_rst_vec = cfg_wide ? `PSBM_RESET_VEC_EXT20 : `PSBM_RESET_VEC_EXT16;
  wire [20:0] ext_wd_vec = cfg_wide ? `PSBM_WDOG_VEC_EXT20 : `PSBM_WDOG_VEC_EXT16;
  wire [20:0] cfg_rst_vec = boot_ext_cap ? ext_rst_vec : `PSBM_RESET_VEC_INT;
  wire [20:0] cfg_wd_vec = boot_ext_cap ? ext_wd_vec : `PSBM_WDOG_VEC_INT;

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  // fixed from capture on; a later map write does not move them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      external_boot <= 1'b0;
      wide_address <= 1'b0;
    end else begin
      external_boot <= boot_ext_cap;
      wide_address <= cfg_wide;
    end
  end

  // secured flash shuts the debug unit and the external space
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      debug_enable <= 1'b0;
      ext_pspace_allowed <= 1'b0;
    end else begin
      debug_enable <= sec_cap;
      ext_pspace_allowed <= sec_cap;
    end
  end

  // chip selects stay program/data strobes; upper pins follow wide mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ext_addr_lines <= `PSBM_NARROW_LINES;
      upper_addr_pin_en <= 4'h0;
      chip_select_strobe_mode <= 1'b1;
    end else begin
      ext_addr_lines <= cfg_lines;
      upper_addr_pin_en <= {4{cfg_wide}};
      chip_select_strobe_mode <= 1'b1;
    end
  end

  // vectors follow the captured strap, not the live map bit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reset_vector <= `PSBM_RESET_VEC_INT;
      watchdog_reset_vector <= `PSBM_WDOG_VEC_INT;
    end else begin
      reset_vector <= cfg_rst_vec;
      watchdog_reset_vector <= cfg_wd_vec;
    end
  end

  // ---------------------------------------------------------------
  // program-space decode
  // ---------------------------------------------------------------
  // map bit is read live so a select write takes effect next cycle
  wire map_ext = boot_map_select;
  wire in_low = (fetch_addr <= `PSBM_LOW_FLASH_TOP);
  wire in_mid = !in_low && (fetch_addr <= `PSBM_MID_FLASH_TOP);
  wire in_hi = (fetch_addr > `PSBM_MID_FLASH_TOP) && (fetch_addr <= `PSBM_HI_FLASH_TOP);
  wire in_boot = (fetch_addr >= `PSBM_BOOT_FLASH_BASE) && (fetch_addr <= `PSBM_BOOT_FLASH_TOP);
  wire in_rsvd = (fetch_addr > `PSBM_BOOT_FLASH_TOP) && (fetch_addr <= `PSBM_RSVD_TOP);
  wire in_pram = (fetch_addr >= `PSBM_PRAM_BASE) && (fetch_addr <= `PSBM_PRAM_TOP);
  // 16-bit ext puts memory over the bottom 64K; 20-bit over boot flash
  wire ext_low = map_ext && !cfg_wide && in_low;
  wire ext_boot = map_ext && cfg_wide && in_boot;

  // limitation: a 16-bit bus reaches only the low 64K of the shadow
  // an external overlay wins over the internal region below it
  psbm_pkg::psbm_target_t dec_target;
  always_comb begin
    if (ext_low || ext_boot) begin
      dec_target = psbm_pkg::PSBM_TGT_EXTERNAL;
    end else if (in_low || in_mid) begin
      dec_target = psbm_pkg::PSBM_TGT_FLASH_A;
    end else if (in_hi) begin
      dec_target = psbm_pkg::PSBM_TGT_FLASH_B;
    end else if (in_boot) begin
      dec_target = psbm_pkg::PSBM_TGT_BOOT_FLASH;
    end else if (in_rsvd) begin
      dec_target = psbm_pkg::PSBM_TGT_RESERVED;
    end else if (in_pram) begin
      dec_target = psbm_pkg::PSBM_TGT_PRAM;
    end else begin
      dec_target = psbm_pkg::PSBM_TGT_EXTERNAL;
    end
  end

  // ---------------------------------------------------------------
  // fetch qualification
  // ---------------------------------------------------------------
  wire hit_ext = (dec_target == psbm_pkg::PSBM_TGT_EXTERNAL);
  wire hit_flash_a = (dec_target == psbm_pkg::PSBM_TGT_FLASH_A);
  wire hit_flash_b = (dec_target == psbm_pkg::PSBM_TGT_FLASH_B);
  // secured parts never drive an off-chip program fetch
  wire dec_ext = hit_ext && ext_pspace_allowed;
  // flags fetches that need pins software has not yet reconfigured
  wire [20:0] bus_limit = cfg_wide ? `PSBM_EXT20_LIMIT : `PSBM_EXT16_LIMIT;
  wire above_bus = (fetch_addr > bus_limit);
  wire dec_beyond = dec_ext && above_bus;
  // each block stalls only its own fetches, the other keeps running
  wire stall_a = hit_flash_a && flash_a_busy;
  wire stall_b = hit_flash_b && flash_b_busy;
  wire dec_stall = stall_a || stall_b;

  // ---------------------------------------------------------------
  // fetch outputs
  // ---------------------------------------------------------------
  // target shows every cycle; the flags only for a qualified fetch
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_target <= psbm_pkg::PSBM_TGT_FLASH_A;
      fetch_to_external <= 1'b0;
    end else begin
      fetch_target <= dec_target;
      fetch_to_external <= fetch_valid && dec_ext;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_beyond_pins <= 1'b0;
      fetch_stall <= 1'b0;
    end else begin
      fetch_beyond_pins <= fetch_valid && dec_beyond;
      fetch_stall <= fetch_valid && dec_stall;
    end
  end
endmodule : psbm_boot_map

/* dv/psbm_boot_map_properties.sv */
// assertions for the program-space boot map block
`timescale 1ns/1ps
module psbm_boot_map_properties (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic map_select_wr,
  input wire logic map_select_wdata,
  input wire logic boot_map_select,
  input wire logic security_mode_flag,
  input wire logic external_boot,
  input wire logic wide_address,
  input wire logic debug_enable,
  input wire logic ext_pspace_allowed,
  input wire logic [4:0] ext_addr_lines,
  input wire logic [3:0] upper_addr_pin_en,
  input wire logic chip_select_strobe_mode,
  input wire logic [20:0] reset_vector,
  input wire logic [20:0] watchdog_reset_vector,
  input wire logic [2:0] fetch_target,
  input wire logic fetch_to_external,
  input wire logic init_done
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  strobe_mode_a: assert property (chip_select_strobe_mode) else $error("strobe mode lost");
  flag_hold_a: assert property (init_done && $past(init_done) |-> $stable(security_mode_flag))
    else $error("security flag moved after capture");
  debug_match_a: assert property ($past(init_done, 2) |-> debug_enable == security_mode_flag)
    else $error("debug enable differs from flag");
  ext_allowed_a: assert property ($past(init_done, 2) |-> ext_pspace_allowed == security_mode_flag)
    else $error("external space permission wrong");
  secured_boot_a: assert property ($past(init_done, 2) && !security_mode_flag |-> !external_boot)
    else $error("external boot while secured");
  map_refuse_a: assert property (init_done && !security_mode_flag |-> !boot_map_select)
    else $error("map select set while secured");
  map_write_a: assert property (init_done && map_select_wr
    |=> boot_map_select == ($past(map_select_wdata) & security_mode_flag))
    else $error("map select write not applied");
  addr_lines_a: assert property ($past(init_done, 2)
    |-> ext_addr_lines == (wide_address ? 5'h14 : 5'h10) && upper_addr_pin_en == {4{wide_address}})
    else $error("address line count wrong");
  vector_pair_a: assert property ($past(init_done, 2) |-> reset_vector == ((external_boot && !wide_address)
    ? 21'h000000 : 21'h040000) && watchdog_reset_vector == reset_vector + 21'h000002)
    else $error("reset vectors wrong");
  wide_ext_a: assert property (wide_address |-> external_boot) else $error("wide without external boot");
  fetch_ext_a: assert property (fetch_to_external |-> security_mode_flag && fetch_target == 3'h5)
    else $error("external fetch not allowed");
  map_switch_c: cover property (init_done && map_select_wr && map_select_wdata ##1 boot_map_select);
  ext_fetch_c: cover property (fetch_to_external);
  wide_boot_c: cover property (wide_address);
endmodule : psbm_boot_map_properties
bind psbm_boot_map psbm_boot_map_properties chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .map_select_wr(map_select_wr), .map_select_wdata(map_select_wdata), .boot_map_select(boot_map_select),
  .security_mode_flag(security_mode_flag), .external_boot(external_boot), .wide_address(wide_address),
  .debug_enable(debug_enable), .ext_pspace_allowed(ext_pspace_allowed), .ext_addr_lines(ext_addr_lines),
  .upper_addr_pin_en(upper_addr_pin_en), .chip_select_strobe_mode(chip_select_strobe_mode),
  .reset_vector(reset_vector), .watchdog_reset_vector(watchdog_reset_vector),
  .fetch_target(fetch_target), .fetch_to_external(fetch_to_external), .init_done(init_done));

/* dv/psbm_ext_mem_model.sv */
// external program memory stand-in counting fetches routed off chip
`timescale 1ns/1ps
module psbm_ext_mem_model (
  input wire logic sys_clk,
  input wire logic fetch_to_external,
  output int ext_fetches
);
  // fetches above the pinned-out range still count; the design flags them apart
  always @(posedge sys_clk) begin
    if (fetch_to_external) ext_fetches <= ext_fetches + 1;
  end
endmodule : psbm_ext_mem_model

/* dv/tb_top.sv */
// testbench for the program-space boot map block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, resetn, fu, xbs, ws, msw, msd, sfw, sfd, fv, fab, fbb, u, e, w;
  logic bms, smf, xb, wa, de, epa, css, fte, fbp, fst, ind;
  logic [20:0] fa, rv, wv;
  logic [4:0] eal;
  logic [3:0] uap;
  logic [2:0] ft;
  int n_fail, compares, cyc, ext_seen, ext_exp;
  logic [20:0] ta [5] = '{21'h000000, 21'h020000, 21'h040000, 21'h044000, 21'h04F800};
  logic [2:0] tt [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  psbm_boot_map dut_u (.sys_clk(sys_clk), .resetn(resetn), .flash_unsecured(fu), .external_boot_strap(xbs),
    .wide_address_strap(ws), .map_select_wr(msw), .map_select_wdata(msd), .security_flag_wr(sfw),
    .security_flag_wdata(sfd), .fetch_addr(fa), .fetch_valid(fv), .flash_a_busy(fab), .flash_b_busy(fbb),
    .boot_map_select(bms), .security_mode_flag(smf), .external_boot(xb), .wide_address(wa),
    .debug_enable(de), .ext_pspace_allowed(epa), .ext_addr_lines(eal), .upper_addr_pin_en(uap),
    .chip_select_strobe_mode(css), .reset_vector(rv), .watchdog_reset_vector(wv), .fetch_target(ft),
    .fetch_to_external(fte), .fetch_beyond_pins(fbp), .fetch_stall(fst), .init_done(ind));
  psbm_ext_mem_model mem_u (.sys_clk(sys_clk), .fetch_to_external(fte), .ext_fetches(ext_seen));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(string nm, logic [20:0] seen, logic [20:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic boot(int i);
    @(negedge sys_clk);
    resetn = 0;
    {u, e, w} = i[2:0];
    {fu, xbs, ws} = {u, e, w};
    repeat (20) @(negedge sys_clk);
    resetn = 1;
    for (int k = 0; k < 10 && ind !== 1'b1; k++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
  endtask : boot
  task automatic wr_map(logic v);
    msw = 1;
    msd = v;
    @(negedge sys_clk);
    msw = 0;
    @(negedge sys_clk);
  endtask : wr_map
  task automatic fetch(logic [20:0] a, logic [2:0] t);
    fa = a;
    fv = 1;
    @(negedge sys_clk);
    fv = 0;
    if (t == 3'h5 && u) ext_exp++;
    check("target", ft, t);
    check("to_ext", fte, t == 3'h5 && u);
    check("beyond", fbp, t == 3'h5 && u && a > ((u & e & w) ? 21'h0FFFFF : 21'h00FFFF));
    check("stall", fst, (t == 3'h0 && fab) || (t == 3'h1 && fbb));
  endtask : fetch
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  // ----------------------------------------
  // sequence: every strap and security combination
  // ----------------------------------------
  initial begin
    {resetn, fu, xbs, ws, msw, msd, sfw, sfd, fv, fab, fbb, fa} = '0;
    for (int i = 0; i < 8; i++) begin
      boot(i);
      check("flag", smf, u);
      check("map", bms, u & e);
      check("ext_boot", xb, u & e);
      check("wide", wa, u & e & w);
      check("lines", eal, (u & e & w) ? 5'h14 : 5'h10);
      check("pins", uap, {4{u & e & w}});
      check("debug", de, u);
      check("ext_ok", epa, u);
      check("rst_vec", rv, (u & e & !w) ? 21'h000000 : 21'h040000);
      check("wd_vec", wv, (u & e & !w) ? 21'h000002 : 21'h040002);
      check("strobe", css, 1'b1);
      {sfw, sfd, fu} = {1'b1, !u, !u};
      @(negedge sys_clk);
      sfw = 0;
      repeat (4) @(negedge sys_clk);
      check("flag_kept", smf, u);
      check("map_kept", bms, u & e);
      wr_map(1);
      check("map_set", bms, u);
      fetch(21'h050000, 3'h5);
      fetch(21'h100000, 3'h5);
      if (u && !(w && !e)) fetch(21'h000000, (e & w) ? 3'h0 : 3'h5);
      if (u & e & w) fetch(21'h040000, 3'h5);
      wr_map(0);
      check("map_clr", bms, 1'b0);
      for (int k = 0; k < 5; k++) begin
        fab = (k == 0) ^ i[0];
        fbb = (k == 1) ^ i[0];
        fetch(ta[k], tt[k]);
      end
      {fab, fbb} = 2'h0;
    end
    check("ext_count", 21'(ext_seen), 21'(ext_exp));
    complete_run();
  end
endmodule : tb_top
